// file: hw/mpot_core.sv
`timescale 1ns/10ps
`include "mpot_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Preload term true enters preload mode unless the observe term is also true
// - Preload clock loads Q from pin
// - Any array input may assert preload
// - Observe term true enters observe mode
// - Observe drives all pins with Q
// - Latch passes when transparent, holds otherwise
// - Latched input change appears on reopening
// - Product-term reset and preset, sampled on mclk
// - Output enable by pin or term
module mpot_core
  import mpot_pkg::*;
#(
  parameter int N = `MPOT_CELLS,
  parameter int NI = `MPOT_DEDIN
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [NI-1:0] ded_in,
  input wire logic clk_pin,
  input wire logic [N-1:0] io_in,
  output logic [N-1:0] io_out,
  output logic [N-1:0] io_oe_n,
  input wire logic oe_pin_n,
  input wire logic [N-1:0] data_term,
  input wire logic [N-1:0] transparency_gate,
  input wire logic [N-1:0] latch_sel,
  input wire logic [N-1:0] polarity_low,
  input wire logic [N-1:0] oe_from_term,
  input wire logic [N-1:0] oe_term,
  input wire logic [N-1:0] areset_term,
  input wire logic [N-1:0] apreset_term,
  input wire logic [NI+N-1:0] preload_and_mask,
  input wire logic [NI+N-1:0] observe_and_mask,
  output mpot_mode_t mode
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NI-1:0] ded_s; // Synchronised dedicated inputs
  logic [N-1:0] io_s; // Synchronised pin levels
  logic clk_s; // Synchronised clock pin
  // Every pin crosses four flops, so a change reaches the array four mclk edges later;
  // the tester must hold each level far longer than that
  mpot_sync #(.W(NI + N + 1)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .din({ded_in, io_in, clk_pin}),
    .dout({ded_s, io_s, clk_s})
  );

  // Storage, mode and pin drive registers; all of them hold while ce is low
  logic [N-1:0] q_q, q_d; // Macrocell storage
  logic clk_q, clk_d; // Previous clock pin level for edge detect
  mpot_mode_t mode_q, mode_d; // Registered mode
  logic [N-1:0] out_q, out_d; // Pin drive value
  logic [N-1:0] oen_q, oen_d; // Pin enable, low drives

  // Product term: AND of all selected array inputs, feedback included
  function automatic logic pterm(input logic [NI+N-1:0] sel,
                                 input logic [NI+N-1:0] vec);
    pterm = &(vec | ~sel);
  endfunction

  // Level shown on a pin for a stored bit; active-low cells show the inverse
  function automatic logic pin_level(input logic q, input logic low);
    pin_level = q ^ low;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode and storage next state
  always_comb begin
    logic [NI+N-1:0] arr;
    logic pre_t, obs_t, rise;
    arr = {ded_s, q_q};
    // Any array input, registers included, may form the terms
    // A term built on feedback can flip itself as preload acts
    pre_t = pterm(preload_and_mask, arr);
    obs_t = pterm(observe_and_mask, arr);
    // Clock pin edge; the pin is synchronised, so this lags by a few mclk cycles
    rise = clk_s & ~clk_q;
    clk_d = clk_s;
    q_d = q_q;
    // Observe wins if both are set: pins must not be driven and sampled at once
    if (obs_t) begin
      mode_d = MPOT_OBSERVE;
    end else if (pre_t) begin
      mode_d = MPOT_PRELOAD;
    end else begin
      mode_d = MPOT_NORMAL;
    end
    for (int i = 0; i < N; i++) begin
      // Reset beats preset, and both beat any clocking or test mode
      if (areset_term[i]) begin
        q_d[i] = 1'b0;
      end else if (apreset_term[i]) begin
        q_d[i] = 1'b1;
      end else if (mode_d == MPOT_PRELOAD) begin
        // Pin carries Q directly; polarity applies only on the way out
        if (rise) begin
          q_d[i] = io_s[i];
        end
      end else if (mode_d == MPOT_OBSERVE) begin
        q_d[i] = q_q[i]; // Observe never disturbs state
      end else if (latch_sel[i]) begin
        // A latched cell ignores the clock pin outside preload mode
        // Transparent follows input; a change while latched shows on reopening
        if (transparency_gate[i]) begin
          q_d[i] = data_term[i];
        end
      end else if (rise) begin
        q_d[i] = data_term[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive next state
  always_comb begin
    // Defaults keep every bit assigned on every path
    out_d = '0;
    oen_d = '1;
    // Test modes override the programmed enable source
    for (int i = 0; i < N; i++) begin
      if (mode_d == MPOT_OBSERVE) begin
        // Raw Q onto every pin, enable forced
        out_d[i] = q_d[i];
        oen_d[i] = 1'b0;
      end else if (mode_d == MPOT_PRELOAD) begin
        // Pins are inputs while the tester writes them
        out_d[i] = pin_level(q_d[i], polarity_low[i]);
        oen_d[i] = 1'b1;
      end else begin
        out_d[i] = pin_level(q_d[i], polarity_low[i]);
        oen_d[i] = oe_from_term[i] ? ~oe_term[i] : oe_pin_n;
      end
    end
  end

  // Registers; reset and preset terms act in the next cycle (sampled)
  // Limitation: a reset or preset pulse shorter than one mclk cycle can be missed
  // Everything freezes while ce is low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_q <= `MPOT_REG_RST;
      clk_q <= 1'b0;
      mode_q <= MPOT_NORMAL;
      out_q <= '0;
      oen_q <= '1;
    end else if (ce) begin
      q_q <= q_d;
      clk_q <= clk_d;
      mode_q <= mode_d;
      out_q <= out_d;
      oen_q <= oen_d;
    end
  end

  // Outputs come straight from flops, so no decode glitch reaches a pin
  assign io_out = out_q;
  assign io_oe_n = oen_q;
  assign mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Terms are sampled, so each check on a term looks one mclk cycle on

  // Observe forces every enable low and shows raw Q, whatever the enable source says
  AST_OBS_DRIVE: assert property (@(posedge mclk) disable iff (!resetn)
    (mode == MPOT_OBSERVE) |-> (io_oe_n == '0 && io_out == q_q))
    else $error("observe does not drive Q on all pins");

  // No pin is driven while the tester may be writing register values
  AST_PRE_RELEASE: assert property (@(posedge mclk) disable iff (!resetn)
    (mode == MPOT_PRELOAD) |-> (io_oe_n == '1))
    else $error("pins driven during preload");

  // Leaving a test mode must not disturb storage
  AST_EXIT_KEEP: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && mode != MPOT_NORMAL && $past(mode) != MPOT_NORMAL && areset_term == '0
     && apreset_term == '0 && mode_d == MPOT_NORMAL && latch_sel == '0 && !(clk_s & ~clk_q))
    |=> (q_q == $past(q_q)))
    else $error("state lost leaving test mode");

  // A reset term clears its cell whatever else is going on
  AST_ARESET: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && areset_term != '0) |=> ((q_q & $past(areset_term)) == '0))
    else $error("reset term ignored");

  // A preload clock edge copies the sampled pin levels into storage
  AST_PRE_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && mode_d == MPOT_PRELOAD && clk_s && !clk_q && areset_term == '0
     && apreset_term == '0) |=> (q_q == $past(io_s)))
    else $error("preload edge did not load pin levels");

  // The observe term decoded afresh must put the array into observe mode
  AST_OBS_ENTER: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && (({ded_s, q_q} | ~observe_and_mask) == '1)) |=> (mode == MPOT_OBSERVE))
    else $error("observe term true but mode not observe");

  // A transparent latch cell follows its data term in normal mode
  AST_LATCH_PASS: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && mode_d == MPOT_NORMAL && areset_term == '0 && apreset_term == '0)
    |=> (((q_q ^ $past(data_term)) & $past(latch_sel & transparency_gate)) == '0))
    else $error("transparent latch did not pass its input");

  // Outside test modes each enable comes from its own term or from the shared pin
  AST_OE_SELECT: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && mode_d == MPOT_NORMAL)
    |=> (io_oe_n == $past((oe_from_term & ~oe_term) | (~oe_from_term & {N{oe_pin_n}}))))
    else $error("enable source not honoured");
endmodule // mpot_core

// file: common/mpot_regs.svh
`ifndef MPOT_REGS_SVH
`define MPOT_REGS_SVH
// Number of macrocells (registers and bidirectional pins)
`define MPOT_CELLS 16
// Number of dedicated inputs feeding the array
`define MPOT_DEDIN 4
// Register reset value
`define MPOT_REG_RST 16'h0000
`endif

// file: common/mpot_pkg.sv
package mpot_pkg;
  // Storage kind of one macrocell
  typedef enum logic {MPOT_FLOP, MPOT_LATCH} mpot_store_t;
  // Operating mode of the array
  typedef enum logic [1:0] {MPOT_NORMAL, MPOT_PRELOAD, MPOT_OBSERVE} mpot_mode_t;
endpackage

// file: hw/mpot_sync.sv
`timescale 1ns/10ps
`include "mpot_regs.svh"
// Three-stage synchroniser; a change counts once stages two and three agree
module mpot_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, o_q;
  logic [W-1:0] o_d;

  // Accept a bit only when the two later stages agree
  always_comb begin
    o_d = o_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        o_d[i] = s3_q[i];
      end
    end
  end

  // Register chain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_q <= '0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_q <= o_d;
    end
  end

  assign dout = o_q;
endmodule // mpot_sync

// file: sim/mpot_tester.sv
`timescale 1ns/10ps
// Tester at the pins; a released pin shows the inverse of its last level
module mpot_tester (
  input wire logic mclk,
  input wire logic drv_en,
  input wire logic [15:0] drv_val,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_n,
  output logic [15:0] io_in
);
  logic [15:0] last_q = 16'h0000; // Last level that either side drove
  // A released pin shows the inverse of the last driven level, never the old value
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (!io_oe_n[i] || drv_en) begin
        last_q[i] <= io_in[i];
      end
    end
  end
  // Device drive wins, then tester drive, else floating
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      io_in[i] = !io_oe_n[i] ? io_out[i] : drv_en ? drv_val[i] : ~last_q[i];
    end
  end
endmodule // mpot_tester

// file: sim/macrocell_preload_observe_test_tb_top.sv
`timescale 1ns/10ps
module macrocell_preload_observe_test_tb_top;
  import mpot_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, clk_pin = 1'b0, oe_pin_n = 1'b1, drv_en = 1'b0;
  logic [3:0] ded = 4'h0;
  logic [15:0] drv_val = 16'h0000, dt = 16'h0000, tg = 16'h0000, ls = 16'h0000;
  logic [15:0] pol = 16'h0000, oft = 16'h0000, oet = 16'h0000, ar = 16'h0000;
  logic [15:0] ap = 16'h0000; // Preset term stimulus
  logic [15:0] io_in, io_out, io_oe_n, v, p, r, d;
  logic [15:0] mdl_q = 16'h0000; // Model of the register contents
  mpot_mode_t mode;
  int miscompares = 0, comparisons = 0;
  always #4 mclk = ~mclk;
  mpot_tester i_mpot_tester (.mclk(mclk), .drv_en(drv_en), .drv_val(drv_val),
    .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in));
  mpot_core i_mpot_core (.mclk(mclk), .resetn(resetn), .ce(1'b1), .ded_in(ded),
    .clk_pin(clk_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .oe_pin_n(oe_pin_n), .data_term(dt), .transparency_gate(tg), .latch_sel(ls),
    .polarity_low(pol), .oe_from_term(oft), .oe_term(oet), .areset_term(ar),
    .apreset_term(ap), .preload_and_mask(20'h80000),
    .observe_and_mask(20'h40000), .mode(mode));
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Count one comparison and report a mismatch
  task automatic note_result(input logic [15:0] got, input logic [15:0] exp,
                             input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Compares read the outputs at the falling edge, where they have settled
  task automatic chk_out(input logic [15:0] exp);
    @(negedge mclk);
    note_result(io_out, exp, "pin value");
    @(posedge mclk);
  endtask
  task automatic chk_oen(input logic [15:0] exp);
    @(negedge mclk);
    note_result(io_oe_n, exp, "pin enable");
    @(posedge mclk);
  endtask
  task automatic chk_mode(input mpot_mode_t exp);
    @(negedge mclk);
    note_result({14'h0, mode}, {14'h0, exp}, "mode");
    @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well beyond the run's length
  initial begin
    step(3000);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(53244));
    v = 16'($urandom);
    p = 16'($urandom);
    r = 16'($urandom);
    d = 16'($urandom);
    step(4);
    resetn <= 1'b1;
    chk_oen(16'hFFFF);
    pol <= p;
    ded <= 4'h8;
    step(12);
    chk_mode(MPOT_PRELOAD);
    drv_en <= 1'b1;
    drv_val <= v;
    step(10);
    clk_pin <= 1'b1;
    step(10);
    clk_pin <= 1'b0;
    mdl_q = v;
    step(10);
    drv_en <= 1'b0;
    step(2);
    ded <= 4'h0;
    oe_pin_n <= 1'b0;
    step(12);
    chk_out(mdl_q ^ p);
    chk_oen(16'h0000);
    $display("preload test done");
    oe_pin_n <= 1'b1;
    ded <= 4'h4;
    step(12);
    chk_mode(MPOT_OBSERVE);
    chk_oen(16'h0000);
    chk_out(mdl_q);
    ded <= 4'h0;
    step(12);
    chk_mode(MPOT_NORMAL);
    chk_oen(16'hFFFF);
    chk_out(mdl_q ^ p);
    $display("observe test done");
    ar <= r;
    ap <= d;
    mdl_q = (mdl_q | d) & ~r;
    step(4);
    ar <= 16'h0000;
    ap <= 16'h0000;
    step(4);
    chk_out(mdl_q ^ p);
    oft <= 16'hFFFF;
    oet <= r;
    step(6);
    chk_oen(~r);
    $display("reset and enable test done");
    ls <= 16'hFFFF;
    tg <= 16'hFFFF;
    dt <= d;
    mdl_q = d;
    step(8);
    chk_out(mdl_q ^ p);
    tg <= 16'h0000;
    step(2);
    dt <= ~d;
    step(8);
    chk_out(mdl_q ^ p);
    tg <= 16'hFFFF;
    mdl_q = ~d;
    step(8);
    chk_out(mdl_q ^ p);
    ls <= 16'h0000;
    dt <= d;
    step(8);
    chk_out(mdl_q ^ p);
    clk_pin <= 1'b1;
    mdl_q = d;
    step(8);
    chk_out(mdl_q ^ p);
    clk_pin <= 1'b0;
    $display("latch test done");
    wrap_up();
  end
endmodule // macrocell_preload_observe_test_tb_top
